//--- dadc_regs.vh
`ifndef DADC_REGS_VH
`define DADC_REGS_VH
// ==========================================
// register offsets (byte addresses)
`define DADC_CTRL_OFF     8'h00
`define DADC_STAT_OFF     8'h04
`define DADC_IRQ_STAT_OFF 8'h08
`define DADC_IRQ_MASK_OFF 8'h0C
`define DADC_SAMP_A_OFF   8'h10
`define DADC_SAMP_B_OFF   8'h14
// ==========================================
// field positions
`define DADC_CTRL_EN_BIT   0
`define DADC_STAT_FMT_BIT  0
`define DADC_STAT_ORA_BIT  1
`define DADC_STAT_ORB_BIT  2
`define DADC_EV_SAMPLE_BIT 0
`define DADC_EV_ORA_BIT    1
`define DADC_EV_ORB_BIT    2
// ==========================================
// reset values
`define DADC_CTRL_RST     1'h1
`define DADC_IRQ_MASK_RST 3'h0
// ==========================================
// timing and bus response codes
`define DADC_LATENCY      8
`define DADC_RESP_OKAY    2'h0
`define DADC_RESP_SLVERR  2'h2
`endif

//--- dadc_chan.v
`timescale 1ns/100ps
`include "dadc_regs.vh"
// ==========================================
// one channel: latency pipe, range check, format
module dadc_chan #(
	parameter WIDTH   = 14,
	parameter LATENCY = `DADC_LATENCY
) (
	// clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// sample in
	input  wire             take,
	input  wire [WIDTH:0]   raw,
	input  wire             gray_sel,
	// result out
	output reg  [WIDTH-1:0] result_ff,
	output reg              over_ff
);
	reg  [WIDTH:0]   pipe_ff [0:LATENCY-1];
	reg  [WIDTH-1:0] nxt_result;
	wire [WIDTH:0]   tail;
	wire             ovr;
	integer          i;

	// raw is WIDTH+1 bit two's complement; beyond WIDTH bits means over range
	assign tail = pipe_ff[LATENCY-1];
	assign ovr  = tail[WIDTH] != tail[WIDTH-1];

	always @* begin
		if (ovr)
			nxt_result = tail[WIDTH] ? {1'b1, {(WIDTH-1){1'b0}}} : {1'b0, {(WIDTH-1){1'b1}}};
		else
			nxt_result = tail[WIDTH-1:0];
		if (gray_sel)
			nxt_result = nxt_result ^ (nxt_result >> 1);
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < LATENCY; i = i + 1)
				pipe_ff[i] <= {(WIDTH+1){1'b0}};
			result_ff <= {WIDTH{1'b0}};
			over_ff   <= 1'b0;
		end else if (take) begin
			pipe_ff[0] <= raw;
			for (i = 1; i < LATENCY; i = i + 1)
				pipe_ff[i] <= pipe_ff[i-1];
			result_ff <= nxt_result;
			over_ff   <= ovr;
		end
	end
endmodule

//--- dadc_top.v
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "dadc_regs.vh"
module dadc_top #(
	parameter WIDTH   = 14,
	parameter LATENCY = `DADC_LATENCY
) (
	// clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// sample clock and converter raw codes
	input  wire             sample_clk,
	input  wire [WIDTH:0]   chan_a_raw,
	input  wire [WIDTH:0]   chan_b_raw,
	input  wire             gray_sel,
	// output port
	output wire [WIDTH-1:0] chan_a_result,
	output wire [WIDTH-1:0] chan_b_result,
	output wire             chan_a_over_range,
	output wire             chan_b_over_range,
	output reg              sample_valid_strobe_ff,
	output reg              irq_ff,
	// axi4-lite write address
	input  wire [7:0]       s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output reg              s_axi_awready,
	// axi4-lite write data
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output reg              s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]       s_axi_araddr,
	input  wire             s_axi_arvalid,
	output reg              s_axi_arready,
	// axi4-lite read data
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready
);
	// ==========================================
	// input synchronisers
	reg  [2:0]       sclk_ff;
	reg  [1:0]       fmt_ff;
	reg  [WIDTH:0]   a_s1_ff;
	reg  [WIDTH:0]   a_s2_ff;
	reg  [WIDTH:0]   b_s1_ff;
	reg  [WIDTH:0]   b_s2_ff;
	wire             take;
	reg              take_d_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sclk_ff <= 3'h0;
			fmt_ff  <= 2'h0;
			a_s1_ff <= {(WIDTH+1){1'b0}};
			a_s2_ff <= {(WIDTH+1){1'b0}};
			b_s1_ff <= {(WIDTH+1){1'b0}};
			b_s2_ff <= {(WIDTH+1){1'b0}};
		end else begin
			sclk_ff <= {sclk_ff[1:0], sample_clk};
			fmt_ff  <= {fmt_ff[0], gray_sel};
			a_s1_ff <= chan_a_raw;
			a_s2_ff <= a_s1_ff;
			b_s1_ff <= chan_b_raw;
			b_s2_ff <= b_s1_ff;
		end
	end

	// edge found on the second and third stages only
	assign take = sclk_ff[1] & ~sclk_ff[2];

	// ==========================================
	// channels
	reg              en_ff;
	wire             take_en = take & en_ff;

	dadc_chan #(.WIDTH(WIDTH), .LATENCY(LATENCY)) u_chan_a (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.take      (take_en),
		.raw       (a_s2_ff),
		.gray_sel  (fmt_ff[1]),
		.result_ff (chan_a_result),
		.over_ff   (chan_a_over_range)
	);

	dadc_chan #(.WIDTH(WIDTH), .LATENCY(LATENCY)) u_chan_b (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.take      (take_en),
		.raw       (b_s2_ff),
		.gray_sel  (fmt_ff[1]),
		.result_ff (chan_b_result),
		.over_ff   (chan_b_over_range)
	);

	// ==========================================
	// valid strobe: low while data updates, rises one clock later
	reg  [3:0]       fill_ff;
	// one take beyond the pipe depth, so the first word flagged is a real sample
	wire             primed = (fill_ff > LATENCY);

	always @(posedge aclk) begin
		if (!aresetn) begin
			take_d_ff              <= 1'b0;
			fill_ff                <= 4'h0;
			sample_valid_strobe_ff <= 1'b0;
		end else begin
			take_d_ff <= take_en;
			if (take_en && !primed)
				fill_ff <= fill_ff + 4'h1;
			if (take_en)
				sample_valid_strobe_ff <= 1'b0;
			else if (take_d_ff && primed)
				sample_valid_strobe_ff <= 1'b1;
		end
	end

	// ==========================================
	// events and interrupt
	reg  [2:0]       irq_stat_ff;
	reg  [2:0]       irq_mask_ff;
	wire [2:0]       ev;
	wire             wr_go;
	reg  [2:0]       w1c;
	reg  [7:0]       wa_ff;
	reg  [31:0]      wd_ff;
	reg  [3:0]       ws_ff;

	assign ev = {take_d_ff & primed & chan_b_over_range,
		take_d_ff & primed & chan_a_over_range,
		take_d_ff & primed};

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= 3'h0;
			irq_ff      <= 1'b0;
		end else begin
			// set wins over a same-cycle clear
			irq_stat_ff <= (irq_stat_ff & ~w1c) | ev;
			irq_ff      <= |(((irq_stat_ff & ~w1c) | ev) & irq_mask_ff);
		end
	end

	// ==========================================
	// axi4-lite write
	reg              aw_have_ff;
	reg              w_have_ff;

	assign wr_go = aw_have_ff & w_have_ff & ~s_axi_bvalid;

	always @* begin
		w1c = 3'h0;
		if (wr_go && wa_ff == `DADC_IRQ_STAT_OFF && ws_ff[0])
			w1c = wd_ff[2:0];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff    <= 1'b0;
			w_have_ff     <= 1'b0;
			wa_ff         <= 8'h00;
			wd_ff         <= 32'h00000000;
			ws_ff         <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DADC_RESP_OKAY;
			en_ff         <= `DADC_CTRL_RST;
			irq_mask_ff   <= `DADC_IRQ_MASK_RST;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && !aw_have_ff && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				aw_have_ff    <= 1'b1;
				wa_ff         <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_ff && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				w_have_ff    <= 1'b1;
				wd_ff        <= s_axi_wdata;
				ws_ff        <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_ff   <= 1'b0;
				w_have_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `DADC_RESP_OKAY;
				case (wa_ff)
				`DADC_CTRL_OFF: begin
					if (ws_ff[0])
						en_ff <= wd_ff[`DADC_CTRL_EN_BIT];
				end
				`DADC_IRQ_MASK_OFF: begin
					if (ws_ff[0])
						irq_mask_ff <= wd_ff[2:0];
				end
				`DADC_IRQ_STAT_OFF: ;
				`DADC_STAT_OFF, `DADC_SAMP_A_OFF, `DADC_SAMP_B_OFF: ;
				default: s_axi_bresp <= `DADC_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// axi4-lite read
	reg  [31:0]      rd_mux;
	reg              rd_bad;

	always @* begin
		rd_bad = 1'b0;
		case (s_axi_araddr)
		`DADC_CTRL_OFF:     rd_mux = {31'h0, en_ff};
		`DADC_STAT_OFF:     rd_mux = {29'h0, chan_b_over_range, chan_a_over_range, fmt_ff[1]};
		`DADC_IRQ_STAT_OFF: rd_mux = {29'h0, irq_stat_ff};
		`DADC_IRQ_MASK_OFF: rd_mux = {29'h0, irq_mask_ff};
		`DADC_SAMP_A_OFF:   rd_mux = {{(32-WIDTH){1'b0}}, chan_a_result};
		`DADC_SAMP_B_OFF:   rd_mux = {{(32-WIDTH){1'b0}}, chan_b_result};
		default: begin
			rd_mux = 32'h00000000;
			rd_bad = 1'b1;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `DADC_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= rd_bad ? `DADC_RESP_SLVERR : `DADC_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

//--- dadc_assertions.sv
`timescale 1ns/100ps
// ==========================================
// port checker
module dadc_checker #(
	parameter WIDTH = 14
) (
	// clock and reset
	input logic             aclk,
	input logic             aresetn,
	// output port
	input logic [WIDTH-1:0] chan_a_result,
	input logic [WIDTH-1:0] chan_b_result,
	input logic             chan_a_over_range,
	input logic             chan_b_over_range,
	input logic             sample_valid_strobe_ff,
	// bus answers
	input logic             s_axi_bvalid,
	input logic             s_axi_bready,
	input logic             s_axi_rvalid,
	input logic             s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence gap_s;
		!sample_valid_strobe_ff ##1 sample_valid_strobe_ff;
	endsequence
	// reset, strobe timing, saturated codes in either format, bus answers
	reset_quiet_a: assert property (disable iff (1'h0)
		!aresetn |=> !sample_valid_strobe_ff && !chan_a_over_range && !chan_b_over_range)
		else $error("outputs not cleared by reset");
	rise_stable_a: assert property (
		$rose(sample_valid_strobe_ff) |-> $stable(chan_a_result) && $stable(chan_b_result))
		else $error("word moved at strobe rise");
	change_low_a: assert property (
		$changed({chan_a_result, chan_b_result, chan_a_over_range, chan_b_over_range})
		|-> !sample_valid_strobe_ff) else $error("word moved while strobe high");
	strobe_gap_a: assert property (
		$fell(sample_valid_strobe_ff) |-> gap_s) else $error("strobe low not one cycle");
	over_a_sat_a: assert property (chan_a_over_range |->
		chan_a_result inside {14'h1FFF, 14'h2000, 14'h1000, 14'h3000})
		else $error("channel a flag without full scale word");
	over_b_sat_a: assert property (chan_b_over_range |->
		chan_b_result inside {14'h1FFF, 14'h2000, 14'h1000, 14'h3000})
		else $error("channel b flag without full scale word");
	bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule

bind dadc_top dadc_checker #(.WIDTH(WIDTH)) u_chk (.aclk, .aresetn, .chan_a_result,
	.chan_b_result, .chan_a_over_range, .chan_b_over_range, .sample_valid_strobe_ff,
	.s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

//--- dadc_backend.sv
`timescale 1ns/100ps
// ==========================================
// back-end capture logic
module dadc_backend (
	// converter port
	input logic         strobe,
	input logic  [13:0] word_a,
	input logic  [13:0] word_b,
	input logic         ovr_a,
	input logic         ovr_b,
	// captured sample
	output logic [13:0] cap_a_ff,
	output logic [13:0] cap_b_ff,
	output logic        cap_ora_ff,
	output logic        cap_orb_ff,
	output int          n_cap_ff
);
	initial n_cap_ff = 0;
	// edge only: a level latch would see the update cycle
	always @(posedge strobe) begin
		cap_a_ff <= word_a;
		cap_b_ff <= word_b;
		cap_ora_ff <= ovr_a;
		cap_orb_ff <= ovr_b;
		n_cap_ff <= n_cap_ff + 1;
	end
endmodule

//--- dual_adc_parallel_output_port_tb.sv
`timescale 1ns/100ps
`include "dadc_regs.vh"
module dual_adc_parallel_output_port_tb;
	logic        aclk = 0, aresetn = 0, sample_clk = 0, gray_sel = 0;
	logic [14:0] chan_a_raw = 0, chan_b_raw = 0;
	logic [13:0] chan_a_result, chan_b_result, cap_a, cap_b;
	logic        chan_a_over_range, chan_b_over_range, sample_valid_strobe_ff, irq_ff;
	logic        cap_ora, cap_orb, awready, wready, bvalid, arready, rvalid;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp;
	int          fails = 0, n_tests = 0, n_cap;
	always #25 aclk = ~aclk;
	// link clock phase unrelated to aclk
	initial #13 forever #200 sample_clk = ~sample_clk;
	dadc_top uut (.aclk, .aresetn, .sample_clk, .chan_a_raw, .chan_b_raw, .gray_sel,
		.chan_a_result, .chan_b_result, .chan_a_over_range, .chan_b_over_range,
		.sample_valid_strobe_ff, .irq_ff, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dadc_backend u_be (.strobe(sample_valid_strobe_ff), .word_a(chan_a_result),
		.word_b(chan_b_result), .ovr_a(chan_a_over_range), .ovr_b(chan_b_over_range),
		.cap_a_ff(cap_a), .cap_b_ff(cap_b), .cap_ora_ff(cap_ora), .cap_orb_ff(cap_orb),
		.n_cap_ff(n_cap));
	// ==========================================
	// helpers
	function automatic logic [13:0] expw(input logic [14:0] r, input logic g);
		logic [13:0] s;
		s = (r[14] ^ r[13]) ? (r[14] ? 14'h2000 : 14'h1FFF) : r[13:0];
		return g ? s ^ (s >> 1) : s;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task wait_s(input int n);
		repeat (n) @(posedge sample_clk);
		repeat (7) @(posedge aclk);
	endtask
	// raw codes change early in the low phase, clear of the sampling edge
	task set_raw(input logic [14:0] a, input logic [14:0] b);
		@(negedge sample_clk);
		@(posedge aclk);
		chan_a_raw <= a;
		chan_b_raw <= b;
	endtask
	task chk_port(input logic [14:0] a, input logic [14:0] b, input logic g);
		chk("word a", expw(a, g), cap_a);
		chk("word b", expw(b, g), cap_b);
		chk("over a", a[14] ^ a[13], cap_ora);
		chk("over b", b[14] ^ b[13], cap_orb);
	endtask
	// waits on the answer alone; only the watchdog ends a hung transfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	// ==========================================
	// scenarios
	task t_latency;
		set_raw(15'h0123, 15'h7FFF);
		wait_s(10);
		set_raw(15'h1555, 15'h7AAA);
		wait_s(8);
		chk_port(15'h0123, 15'h7FFF, 1'h0);
		wait_s(1);
		chk_port(15'h1555, 15'h7AAA, 1'h0);
	endtask
	task t_format;
		logic [14:0] va [3] = '{15'h1FFF, 15'h2000, 15'h0ABC};
		logic [14:0] vb [3] = '{15'h6000, 15'h5FFF, 15'h7123};
		for (int g = 0; g < 2; g++)
			for (int i = 0; i < 3; i++) begin
				@(posedge aclk);
				gray_sel <= g[0];
				set_raw(va[i], vb[i]);
				wait_s(10);
				chk_port(va[i], vb[i], g[0]);
			end
	endtask
	task t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		rd(`DADC_CTRL_OFF, d, r);
		chk("ctrl", 32'h1, d);
		rd(`DADC_IRQ_MASK_OFF, d, r);
		chk("mask", 32'h0, d);
		rd(8'h40, d, r);
		chk("resp", `DADC_RESP_SLVERR, r);
		wr(8'h40, 32'h0);
		chk("bresp bad", `DADC_RESP_SLVERR, bresp);
		rd(`DADC_STAT_OFF, d, r);
		chk("stat", 32'h1, d);
		rd(`DADC_SAMP_B_OFF, d, r);
		chk("samp b", expw(15'h7123, 1'h1), d);
		chk("irq off", 1'h0, irq_ff);
		wr(`DADC_IRQ_MASK_OFF, 32'h1);
		chk("bresp ok", `DADC_RESP_OKAY, bresp);
		wait_s(1);
		chk("irq on", 1'h1, irq_ff);
		wr(`DADC_CTRL_OFF, 32'h0);
		wr(`DADC_IRQ_STAT_OFF, 32'h7);
		n = n_cap;
		wait_s(2);
		chk("irq clr", 1'h0, irq_ff);
		chk("frozen", n, n_cap);
		wr(`DADC_CTRL_OFF, 32'h1);
		wait_s(2);
		chk("resume", 1'h1, n_cap > n);
	endtask
	task close_out;
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		t_latency;
		t_format;
		t_regs;
		close_out;
	end
	initial begin
		#200000;
		fails++;
		close_out;
	end
endmodule
